// >>> dv/serial_length_steered_loader_bench.sv
`timescale 1ns/1ps
`include "loader_consts.svh"
module serial_length_steered_loader_bench
    import loader_pkg::*;
;
    logic                    ref_clk;
    logic                    rst_n;
    logic                    sel_n;
    logic                    sclk;
    logic                    din;
    logic                    dout;
    logic                    dout_oe;
    logic [`SETUP_W-1:0]     setup_w;
    logic [`FEEDBACK_W-1:0]  fb_w;
    logic [`REFERENCE_W-1:0] ref_w;
    logic [`SETUP_W-1:0]     exp_s;
    logic [`FEEDBACK_W-1:0]  exp_f;
    logic [`REFERENCE_W-1:0] exp_r;
    logic                    ld_s;
    logic                    ld_f;
    logic                    ld_r;
    logic                    rst_seen;
    logic                    casc;
    logic                    lost;
    logic [6:0]              flg;
    logic [38:0]             prev_w;
    int                      n_fail;
    int                      checked;
    int                      lens[4] = '{24, 8, 15, 16};

    spi_master_model #(.HOLD(3)) mst (
        .ref_clk (ref_clk),
        .dout    (dout),
        .dout_oe (dout_oe),
        .sel_n   (sel_n),
        .sclk    (sclk),
        .din     (din)
    );

    serial_length_steered_loader DUT (
        .ref_clk               (ref_clk),
        .rst_n                 (rst_n),
        .port_select_n         (sel_n),
        .serial_clk            (sclk),
        .serial_din            (din),
        .serial_dout           (dout),
        .serial_dout_oe        (dout_oe),
        .setup_word_reg        (setup_w),
        .feedback_divide_word  (fb_w),
        .reference_divide_word (ref_w),
        .setup_load            (ld_s),
        .feedback_load         (ld_f),
        .reference_load        (ld_r),
        .reset_pattern_seen    (rst_seen),
        .cascade_seen          (casc),
        .sync_lost             (lost)
    );

    initial
        ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    // sticky pulse flags; bit 6 marks a word moving while selected
    // sampled on the falling edge, away from output updates
    always @(negedge ref_clk)
    begin
        flg[5:0] <= flg[5:0] | {lost, casc, rst_seen, ld_r, ld_f, ld_s};
        if (sel_n === 1'b0 && {setup_w, fb_w, ref_w} !== prev_w)
            flg[6] <= 1'b1;
        prev_w <= {setup_w, fb_w, ref_w};
    end

    task automatic check(input logic [40:0] got, input logic [40:0] want, input string what);
        checked++;
        if (got !== want)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one transfer of n clocks, then every outcome except sync loss compared
    task automatic run(input int n, input logic [39:0] data);
        @(posedge ref_clk);
        flg = '0;
        mst.xfer(n, data, 1'b0);
        @(negedge ref_clk);
        if (n == 8)
            exp_s = data[7:0];
        if (n == 16)
            exp_f = data[15:0];
        if (n == 15 || n == 24)
            exp_r = data[14:0];
        check(setup_w, exp_s, "setup word");
        check(fb_w, exp_f, "feedback word");
        check(ref_w, exp_r, "reference word");
        check(flg[2:0], {n == 15 || n == 24, n == 16, n == 8}, "load pulses");
        check(flg[3], n >= 9 && n <= 13, "reset pattern");
        check(flg[4], n > 32, "cascade");
        check(flg[6], 1'b0, "word moved while shifting");
        check({mst.oe_ok, dout_oe}, 2'b10, "output enable");
        for (int j = 17; j <= n; j++)
            check(mst.rx[j-1], data[n-j+16], "dout");
    endtask

    initial
    begin
        rst_n  = 1'b0;
        n_fail = 0;
        checked = 0;
        flg    = '0;
        prev_w = '0;
        exp_s  = 8'h00;
        exp_f  = 16'h0000;
        exp_r  = 15'h0000;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check({setup_w, fb_w, ref_w, dout_oe, lost}, 41'h0, "reset state");
        for (int n = 1; n <= 40; n++)
            run(n, 40'hd35ac3e196 ^ {5{n[7:0]}});
        mst.slow = 3;
        foreach (lens[i])
            run(lens[i], 40'h1b2c3d4e5f + 40'h0f1e2d * i);
        mst.slow = 0;
        @(posedge ref_clk);
        flg = '0;
        mst.xfer(8, 40'h3c, 1'b1);
        @(negedge ref_clk);
        check({flg[5], flg[0], setup_w}, {2'b10, exp_s}, "lost sync, no load");
        check(lost, 1'b0, "resynchronised");
        run(8, 40'h96);
        print_verdict;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict;
    end
endmodule

// >>> dv/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model
    import loader_pkg::*;
#(
    parameter int HOLD = 3
)
(
    input  wire logic ref_clk,  // system clock
    input  wire logic dout,     // device serial output
    input  wire logic dout_oe,  // device output enable
    output logic      sel_n,    // select to device, active low
    output logic      sclk,     // shift clock to device
    output logic      din       // serial data to device
);
    logic [39:0] rx;     // dout seen just before each rising clock
    logic        oe_ok;  // enable seen high at every sample
    int          slow;   // extra cycles per clock level

    initial
    begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        din   = 1'b0;
        rx    = '0;
        oe_ok = 1'b1;
        slow  = 0;
    end

    // n clocks of data[n-1:0]; bad releases select with clock high
    task automatic xfer(input int n, input logic [39:0] data, input bit bad);
        oe_ok = 1'b1;
        @(posedge ref_clk);
        sel_n <= 1'b0;
        for (int j = 1; j <= n; j++)
        begin
            sclk <= 1'b0;
            din  <= data[n-j];
            repeat (HOLD + slow) @(posedge ref_clk);
            @(negedge ref_clk);
            rx[j-1] = dout_oe ? dout : ~dout;
            if (dout_oe !== 1'b1)
                oe_ok = 1'b0;
            @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (HOLD + slow) @(posedge ref_clk);
        end
        if (!bad)
        begin
            sclk <= 1'b0;
            repeat (HOLD) @(posedge ref_clk);
        end
        sel_n <= 1'b1;
        din   <= ~din;
        if (bad)
        begin
            repeat (2) @(posedge ref_clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
    endtask
endmodule

// >>> src/length_decoder.sv
`timescale 1ns/1ps
`include "loader_consts.svh"
module length_decoder
    import loader_pkg::*;
(
    input  wire logic [`COUNT_W-1:0] clk_count,  // clocks seen while selected
    output target_t                  target      // chosen destination
);

    // only the length steers; no stream bit is an address
    always_comb
    begin
        if (clk_count > `LEN_SINGLE_MAX)
            target = TGT_CASCADE;
        else if (clk_count == `LEN_SETUP)
            target = TGT_SETUP;
        else if (clk_count == `LEN_FEEDBACK)
            target = TGT_FEEDBACK;
        else if (clk_count == `LEN_REF_SHORT || clk_count == `LEN_REF_LONG)
            target = TGT_REFERENCE;
        else if (clk_count >= `LEN_RST_MIN && clk_count <= `LEN_RST_MAX)
            target = TGT_RESET;
        else
            target = TGT_NONE;
    end

endmodule

// >>> src/loader_consts.svh
`ifndef LOADER_CONSTS_SVH
`define LOADER_CONSTS_SVH

// word, shift chain and counter widths
`define SETUP_W        8
`define FEEDBACK_W     16
`define REFERENCE_W    15
`define SHIFT_W        24
`define COUNT_W        6

// transfer lengths in serial clocks
`define LEN_SETUP      6'h08
`define LEN_FEEDBACK   6'h10
`define LEN_REF_SHORT  6'h0f
`define LEN_REF_LONG   6'h18
`define LEN_RST_MIN    6'h09
`define LEN_RST_MAX    6'h0d
`define LEN_SINGLE_MAX 6'h20
`define COUNT_SAT      6'h21

// serial output tap: half stage behind the sixteenth stage of the twenty-four stage chain
`define DOUT_TAP       15

// reset values
`define SETUP_RST      8'h00
`define FEEDBACK_RST   16'h0000
`define REFERENCE_RST  15'h0000
`define SHIFT_RST      24'h000000

`endif

// >>> src/loader_pkg.sv
package loader_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LOST  = 3'b100
    } port_state_t;

    typedef enum logic [2:0]
    {
        TGT_NONE      = 3'h0,
        TGT_SETUP     = 3'h1,
        TGT_FEEDBACK  = 3'h2,
        TGT_REFERENCE = 3'h3,
        TGT_RESET     = 3'h4,
        TGT_CASCADE   = 3'h5
    } target_t;

endpackage

// >>> src/pin_edge_sampler.sv
`timescale 1ns/1ps
module pin_edge_sampler
    import loader_pkg::*;
(
    input  wire logic ref_clk,        // system clock
    input  wire logic rst_n,          // async reset, active low
    input  wire logic serial_clk,     // shift clock pin
    input  wire logic port_select_n,  // select pin, active low
    output logic      sclk_hi,        // shift clock level last cycle
    output logic      sel_n_hi,       // select level last cycle
    output logic      sclk_rise,      // shift clock rising this cycle
    output logic      sclk_fall,      // shift clock falling this cycle
    output logic      sel_rise,       // select released this cycle
    output logic      sel_fall        // select asserted this cycle
);

    typedef struct packed
    {
        logic sclk;
        logic sel_n;
    } pins_t;

    pins_t q;
    pins_t d;

    always_comb
    begin
        d       = q;
        d.sclk  = serial_clk;
        d.sel_n = port_select_n;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.sclk  <= 1'b0;
            q.sel_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign sclk_hi   = q.sclk;
    assign sel_n_hi  = q.sel_n;
    assign sclk_rise = serial_clk & ~q.sclk;
    assign sclk_fall = ~serial_clk & q.sclk;
    assign sel_rise  = port_select_n & ~q.sel_n;
    assign sel_fall  = ~port_select_n & q.sel_n;

endmodule

// >>> src/serial_length_steered_loader.sv
`timescale 1ns/1ps
`include "loader_consts.svh"
// Functional notes
// - stream arrives msb first; each bit sampled on shift clock rising edge.
// - exactly eight clocks load the eight-bit setup word, bit 7 first.
// - exactly sixteen clocks load the sixteen-bit feedback divide word, bit 15 first.
// - fifteen or twenty-four clocks load the fifteen-bit reference divide word.
// - bit 0 of every word is its lsb and the last bit shifted.
// - stored words hold during shifting; update only at select release.
// - no address bits; target chosen purely from transfer length.
// - words may be loaded in any order.
// - nine to thirteen clocks flag the reset pattern, no word load.
// - any other length up to thirty-two loads nothing.
// - more than thirty-two clocks is cascade operation, no single-device load.
// - select rising edge copies shifted data into the word chosen by length when shift clock is low at both select edges.
// - while deselected, clocks ignored, output high impedance, port initialised.
// - serial output updates from the shift chain on shift clock falling edge.
module serial_length_steered_loader
    import loader_pkg::*;
(
    input  wire logic                     ref_clk,               // system clock, 125 MHz
    input  wire logic                     rst_n,                 // async reset, active low
    input  wire logic                     port_select_n,         // port select, active low
    input  wire logic                     serial_clk,            // shift clock from master
    input  wire logic                     serial_din,            // serial data in
    output logic                          serial_dout,           // serial data out
    output logic                          serial_dout_oe,        // high while dout is driven
    output logic [`SETUP_W-1:0]           setup_word_reg,        // setup word
    output logic [`FEEDBACK_W-1:0]        feedback_divide_word,  // feedback divide word
    output logic [`REFERENCE_W-1:0]       reference_divide_word, // reference divide word
    output logic                          setup_load,            // setup word just updated
    output logic                          feedback_load,         // feedback word just updated
    output logic                          reference_load,        // reference word just updated
    output logic                          reset_pattern_seen,    // nine to thirteen clock transfer
    output logic                          cascade_seen,          // transfer beyond thirty-two clocks
    output logic                          sync_lost              // port waiting to resynchronise
);

    typedef struct packed
    {
        port_state_t                state;
        logic [`COUNT_W-1:0]        cnt;
        logic [`SHIFT_W-1:0]        shift;
        logic                       dout;
        logic                       dout_oe;
        logic [`SETUP_W-1:0]        setup;
        logic [`FEEDBACK_W-1:0]     feedback;
        logic [`REFERENCE_W-1:0]    reference;
        logic                       setup_ld;
        logic                       feedback_ld;
        logic                       reference_ld;
        logic                       rst_pat;
        logic                       cascade;
    } loader_state_t;

    loader_state_t q;
    loader_state_t d;

    logic    sclk_hi;
    logic    sel_n_hi;
    logic    sclk_rise;
    logic    sclk_fall;
    logic    sel_rise;
    logic    sel_fall;
    target_t target;

    pin_edge_sampler u_pins
    (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .serial_clk    (serial_clk),
        .port_select_n (port_select_n),
        .sclk_hi       (sclk_hi),
        .sel_n_hi      (sel_n_hi),
        .sclk_rise     (sclk_rise),
        .sclk_fall     (sclk_fall),
        .sel_rise      (sel_rise),
        .sel_fall      (sel_fall)
    );

    length_decoder u_len
    (
        .clk_count (q.cnt),
        .target    (target)
    );

    always_comb
    begin
        d              = q;
        d.setup_ld     = 1'b0;
        d.feedback_ld  = 1'b0;
        d.reference_ld = 1'b0;
        d.rst_pat      = 1'b0;
        d.cascade      = 1'b0;
        case (q.state)
            ST_IDLE:
            begin
                d.cnt     = '0;
                d.dout_oe = 1'b0;
                if (sel_fall)
                begin
                    if (sclk_hi)
                        d.state = ST_LOST;
                    else
                    begin
                        d.state   = ST_SHIFT;
                        d.dout_oe = 1'b1;
                    end
                end
            end
            ST_SHIFT:
            begin
                if (sel_rise)
                begin
                    d.cnt     = '0;
                    d.dout_oe = 1'b0;
                    if (sclk_hi)
                        d.state = ST_LOST;
                    else
                    begin
                        d.state = ST_IDLE;
                        // words change only here, in any order
                        case (target)
                            TGT_SETUP:
                            begin
                                d.setup    = q.shift[`SETUP_W-1:0];
                                d.setup_ld = 1'b1;
                            end
                            TGT_FEEDBACK:
                            begin
                                d.feedback    = q.shift[`FEEDBACK_W-1:0];
                                d.feedback_ld = 1'b1;
                            end
                            TGT_REFERENCE:
                            begin
                                // last fifteen bits; a twenty-four clock transfer drops its earlier nine
                                d.reference    = q.shift[`REFERENCE_W-1:0];
                                d.reference_ld = 1'b1;
                            end
                            TGT_RESET:
                                d.rst_pat = 1'b1;
                            TGT_CASCADE:
                                d.cascade = 1'b1;
                            default:
                                d.rst_pat = 1'b0;
                        endcase
                    end
                end
                else
                begin
                    if (sclk_rise)
                    begin
                        d.shift = {q.shift[`SHIFT_W-2:0], serial_din};
                        if (q.cnt != `COUNT_SAT)
                            d.cnt = q.cnt + 6'h01;
                    end
                    if (sclk_fall)
                        d.dout = q.shift[`DOUT_TAP];
                end
            end
            ST_LOST:
            begin
                d.cnt     = '0;
                d.dout_oe = 1'b0;
                if (sel_n_hi && port_select_n && !serial_clk)
                    d.state = ST_IDLE;
            end
            default:
            begin
                d.state   = ST_IDLE;
                d.cnt     = '0;
                d.dout_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.state        <= ST_IDLE;
            q.cnt          <= '0;
            q.shift        <= `SHIFT_RST;
            q.dout         <= 1'b0;
            q.dout_oe      <= 1'b0;
            q.setup        <= `SETUP_RST;
            q.feedback     <= `FEEDBACK_RST;
            q.reference    <= `REFERENCE_RST;
            q.setup_ld     <= 1'b0;
            q.feedback_ld  <= 1'b0;
            q.reference_ld <= 1'b0;
            q.rst_pat      <= 1'b0;
            q.cascade      <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign serial_dout           = q.dout;
    assign serial_dout_oe        = q.dout_oe;
    assign setup_word_reg        = q.setup;
    assign feedback_divide_word  = q.feedback;
    assign reference_divide_word = q.reference;
    assign setup_load            = q.setup_ld;
    assign feedback_load         = q.feedback_ld;
    assign reference_load        = q.reference_ld;
    assign reset_pattern_seen    = q.rst_pat;
    assign cascade_seen          = q.cascade;
    assign sync_lost             = (q.state == ST_LOST);

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic any_load;
    assign any_load = q.setup_ld | q.feedback_ld | q.reference_ld;

    sequence s_clean_end;
        q.state == ST_SHIFT && sel_rise && !sclk_hi;
    endsequence

    sequence s_clean_end_len(logic [5:0] len);
        s_clean_end and (q.cnt == len);
    endsequence

    a_msb_first_shift: assert property (
        q.state == ST_SHIFT && !sel_rise && sclk_rise
        |=> q.shift == {$past(q.shift[22:0]), $past(serial_din)})
        else $error("shift chain did not take din at lsb");

    a_setup_by_len: assert property (
        s_clean_end_len(6'h08)
        |=> setup_load && setup_word_reg == $past(q.shift[7:0]) && !feedback_load && !reference_load)
        else $error("eight clock transfer did not load setup word");

    a_feedback_by_len: assert property (
        s_clean_end_len(6'h10)
        |=> feedback_load && feedback_divide_word == $past(q.shift[15:0]) && !setup_load)
        else $error("sixteen clock transfer did not load feedback word");

    a_reference_by_len: assert property (
        (s_clean_end_len(6'h0f) or s_clean_end_len(6'h18))
        |=> reference_load && reference_divide_word == $past(q.shift[14:0]))
        else $error("reference transfer did not load last fifteen bits");

    a_words_hold_shift: assert property (
        !$past(sel_rise) |-> $stable(setup_word_reg) && $stable(feedback_divide_word)
        && $stable(reference_divide_word))
        else $error("stored word changed without select release");

    a_reset_no_load: assert property (
        s_clean_end and (q.cnt >= 6'h09 && q.cnt <= 6'h0d)
        |=> reset_pattern_seen && !any_load)
        else $error("reset pattern length mishandled");

    a_other_no_load: assert property (
        s_clean_end and (q.cnt <= 6'h20) and !(q.cnt == 6'h08 || q.cnt == 6'h10
        || q.cnt == 6'h0f || q.cnt == 6'h18 || (q.cnt >= 6'h09 && q.cnt <= 6'h0d))
        |=> !any_load && !reset_pattern_seen && !cascade_seen)
        else $error("unlisted length loaded a word");

    a_cascade_len: assert property (
        s_clean_end and (q.cnt > 6'h20) |=> cascade_seen && !any_load)
        else $error("long transfer treated as a load");

    a_idle_hiz: assert property (
        port_select_n && sel_n_hi ##1 port_select_n |-> !serial_dout_oe && q.cnt == 6'h00)
        else $error("port active while deselected");

    a_dout_on_fall: assert property (
        q.state == ST_SHIFT && !sel_rise && sclk_fall |=> serial_dout == $past(q.shift[15]))
        else $error("dout not updated on falling shift clock");

    a_count_sat: assert property (
        q.cnt == 6'h21 && sclk_rise && q.state == ST_SHIFT && !sel_rise |=> q.cnt == 6'h21)
        else $error("clock counter did not saturate");

    a_count_step: assert property (
        q.state == ST_SHIFT && !sel_rise && sclk_rise && q.cnt != 6'h21 |=> q.cnt == $past(q.cnt) + 6'h01)
        else $error("clock counter missed a rising shift clock");

    a_load_on_release: assert property (
        any_load |-> $past(sel_rise) && $past(q.state) == ST_SHIFT)
        else $error("word loaded without select release");

    a_oe_after_select: assert property (
        q.state == ST_IDLE && sel_fall && !sclk_hi |=> serial_dout_oe && q.state == ST_SHIFT)
        else $error("output not enabled after select fall");

    a_chain_held_idle: assert property (
        q.state != ST_SHIFT |=> $stable(q.shift))
        else $error("shift chain moved while deselected");

    a_long_ref_tail: assert property (
        s_clean_end_len(6'h18) |=> reference_divide_word == $past(q.shift[14:0]) && !setup_load)
        else $error("long reference load kept wrong bits");

endmodule
